// ---- core/ufpt_pkg.sv ----
// Constants and types for the USB pin-test and request routing block
package ufpt_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_OUT_TEST = 8'h00;
	localparam logic [7:0] OFS_IN_MON   = 8'h04;
	localparam logic [7:0] OFS_BUS_FLG  = 8'h08;
	localparam logic [7:0] OFS_CTL_FLG  = 8'h0c;
	localparam logic [7:0] OFS_DAT_FLG  = 8'h10;
	localparam logic [7:0] OFS_SEL_BUS  = 8'h14;
	localparam logic [7:0] OFS_SEL_CTL  = 8'h18;
	localparam logic [7:0] OFS_SEL_DAT  = 8'h1c;

	// Output test register fields
	localparam int OT_PTE_BIT  = 7;
	localparam int OT_SUSP_BIT = 3;
	localparam int OT_OEN_BIT  = 2;
	localparam int OT_SE0_BIT  = 1;
	localparam int OT_DATA_BIT = 0;
	localparam logic [7:0] OT_WMASK = 8'h8f;

	// Input monitor register fields
	localparam int MON_DIFF_BIT = 2;
	localparam int MON_DP_BIT   = 1;
	localparam int MON_DM_BIT   = 0;

	// Flag banks: 0 bus status, 1 control endpoint, 2 data endpoint
	localparam int NUM_BANKS = 3;
	localparam logic [NUM_BANKS-1:0][7:0] IRQ_MASK = {8'h3f, 8'h1f, 8'hdd};
	localparam int BUS_PWR_STAT_BIT = 1;
	localparam int BUS_SUSP_STAT_BIT = 5;
	localparam int BUS_BANK = 0;
	localparam int DAT_BANK = 2;
	localparam int DAT_BO_FULL_BIT = 0;
	localparam int DAT_BI_EMPTY_BIT = 2;

	// Reset values
	localparam logic [7:0]  REG_RST   = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// Drive toward the on-chip transceiver
	typedef struct packed {
		logic suspend;
		logic oe_n;
		logic plus_line;
		logic minus_line;
	} ufpt_xcvr_t;

	// Lines released, idle J level on the value pins
	localparam ufpt_xcvr_t XCVR_RST = ufpt_xcvr_t'(4'h6);
endpackage : ufpt_pkg

// ---- core/ufpt_top.sv ----
// USB function pin-test registers and interrupt/DMA request routing
//
// Operation
// - Pin test enable drives lines from register
// - Output enabled, no SE0: plus=value, minus=inverse
// - Output enabled with SE0: both lines low
// - Output enable-low set: both lines released
// - Test disabled: normal drive passes through
// - Monitor active with test, enable-low and power
// - Monitor reads zero without power or test
// - Monitor awake: lines direct, differential reported
// - Monitor asleep: differential bit reads zero
// - Reserved test bits read zero, write zero
// - Four active-low level request outputs, one wake pulse
// - First flag register layout, status non-interrupting
// - Second flag register layout, upper reserved
// - Third flag layout, bulk-out full to DMA0
// - Only bulk-in empty drives DMA1
// - Line A low for select-zero set flags
// - Line B low for its set flags
// - Wake output low on resume transition
`timescale 1ns/1ps
module ufpt_top
	import ufpt_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire ufpt_pkg::ufpt_xcvr_t  nrm_xcvr,
	output ufpt_pkg::ufpt_xcvr_t       xcvr,
	input  wire logic                  rx_plus_line,
	input  wire logic                  rx_minus_line,
	input  wire logic                  rx_diff,
	input  wire logic                  bus_power_status,
	input  wire logic                  suspend_resume_state,
	input  wire logic [7:0]            ev_bus,
	input  wire logic [4:0]            ev_ctl,
	input  wire logic [5:0]            ev_dat,
	output logic                       dma_request_line_0_n,
	output logic                       dma_request_line_1_n,
	output logic                       cpu_irq_line_a_n,
	output logic                       cpu_irq_line_b_n,
	output logic                       wake_n
);
	import ufpt_pkg::*;

	logic [7:0]       ot_ff;
	logic [7:0]       mon_ff;
	logic [7:0]       flg_ff [NUM_BANKS];
	logic [7:0]       sel_ff [NUM_BANKS];
	logic [31:0]      prdata_ff;
	logic             pready_ff;
	logic             pslverr_ff;
	ufpt_xcvr_t       xcvr_ff;
	logic             dma0_n_ff;
	logic             dma1_n_ff;
	logic             irq_a_n_ff;
	logic             irq_b_n_ff;
	logic             wake_n_ff;
	logic             susp_q_ff;

	// Bus phases
	wire              acc_w;
	wire              req_w;
	wire              wr_w;
	wire              hit_ot;
	wire              hit_mon;
	wire [NUM_BANKS-1:0] hit_flg;
	wire [NUM_BANKS-1:0] hit_sel;
	wire              mapped_w;
	wire [7:0]        rd_val;
	wire [7:0]        ev_w   [NUM_BANKS];
	wire [7:0]        nxt_flg [NUM_BANKS];
	wire [NUM_BANKS-1:0] pend_a;
	wire [NUM_BANKS-1:0] pend_b;

	// Access phase waiting for the answer, and the completing edge
	assign req_w = psel & penable & ~pready_ff;
	assign acc_w = psel & penable & pready_ff;
	assign wr_w  = acc_w & pwrite;

	assign hit_ot   = (paddr == OFS_OUT_TEST);
	assign hit_mon  = (paddr == OFS_IN_MON);
	assign hit_flg  = {paddr == OFS_DAT_FLG, paddr == OFS_CTL_FLG, paddr == OFS_BUS_FLG};
	assign hit_sel  = {paddr == OFS_SEL_DAT, paddr == OFS_SEL_CTL, paddr == OFS_SEL_BUS};
	assign mapped_w = hit_ot | hit_mon | (|hit_flg) | (|hit_sel);

	assign rd_val = hit_ot     ? ot_ff :
	                hit_mon    ? mon_ff :
	                hit_flg[0] ? flg_ff[0] :
	                hit_flg[1] ? flg_ff[1] :
	                hit_flg[2] ? flg_ff[2] :
	                hit_sel[0] ? sel_ff[0] :
	                hit_sel[1] ? sel_ff[1] :
	                hit_sel[2] ? sel_ff[2] : REG_RST;

	// One wait state, then the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= RDATA_RST;
		end else begin
			pready_ff  <= req_w;
			pslverr_ff <= req_w & ~mapped_w;
			if (req_w & ~pwrite) begin
				prdata_ff <= {24'h00_0000, rd_val};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ot_ff <= REG_RST;
		end else if (wr_w & hit_ot) begin
			ot_ff <= pwdata[7:0] & OT_WMASK;
		end
	end

	// Output test decode
	wire pte_w  = ot_ff[OT_PTE_BIT];
	wire oen_w  = ot_ff[OT_OEN_BIT];
	wire se0_w  = ot_ff[OT_SE0_BIT];
	wire data_w = ot_ff[OT_DATA_BIT];
	wire susp_w = ot_ff[OT_SUSP_BIT];
	ufpt_xcvr_t tst_xcvr;
	ufpt_xcvr_t nxt_xcvr;
	wire        tst_plus;
	wire        tst_minus;

	assign tst_plus  = ~se0_w & data_w;
	assign tst_minus = ~se0_w & ~data_w;
	assign tst_xcvr  = {susp_w, oen_w, tst_plus, tst_minus};

	assign nxt_xcvr = pte_w ? tst_xcvr : nrm_xcvr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xcvr_ff <= XCVR_RST;
		end else begin
			xcvr_ff <= nxt_xcvr;
		end
	end

	wire mon_act = pte_w & oen_w & bus_power_status;
	wire [7:0] nxt_mon;

	assign nxt_mon = mon_act ?
	                 {5'h00, rx_diff & ~susp_w, rx_plus_line, rx_minus_line} :
	                 REG_RST;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mon_ff <= REG_RST;
		end else begin
			mon_ff <= nxt_mon;
		end
	end

	assign ev_w[0] = ev_bus;
	assign ev_w[1] = {3'h0, ev_ctl};
	assign ev_w[2] = {2'h0, ev_dat};

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			wire [7:0] clr_w;
			wire [7:0] held_w;
			assign clr_w  = (wr_w & hit_flg[b]) ? pwdata[7:0] : REG_RST;
			// Event set wins over a write-one clear
			assign held_w = ((flg_ff[b] & ~clr_w) | ev_w[b]) & IRQ_MASK[b];
			if (b == BUS_BANK) begin : g_stat
				assign nxt_flg[b] = held_w |
				                    (8'(bus_power_status) << BUS_PWR_STAT_BIT) |
				                    (8'(suspend_resume_state) << BUS_SUSP_STAT_BIT);
			end else begin : g_plain
				assign nxt_flg[b] = held_w;
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flg_ff[b] <= REG_RST;
					sel_ff[b] <= REG_RST;
				end else begin
					flg_ff[b] <= nxt_flg[b];
					if (wr_w & hit_sel[b]) begin
						sel_ff[b] <= pwdata[7:0] & IRQ_MASK[b];
					end
				end
			end

			assign pend_a[b] = |(flg_ff[b] & IRQ_MASK[b] & ~sel_ff[b]);
			assign pend_b[b] = |(flg_ff[b] & IRQ_MASK[b] & sel_ff[b]);
		end
	endgenerate

	// Resume transition: suspended last cycle, not now
	wire resume_w = susp_q_ff & ~suspend_resume_state;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma0_n_ff  <= 1'b1;
			dma1_n_ff  <= 1'b1;
			irq_a_n_ff <= 1'b1;
			irq_b_n_ff <= 1'b1;
			wake_n_ff  <= 1'b1;
			susp_q_ff  <= 1'b0;
		end else begin
			dma0_n_ff  <= ~flg_ff[DAT_BANK][DAT_BO_FULL_BIT];
			dma1_n_ff  <= ~flg_ff[DAT_BANK][DAT_BI_EMPTY_BIT];
			irq_a_n_ff <= ~(|pend_a);
			irq_b_n_ff <= ~(|pend_b);
			susp_q_ff  <= suspend_resume_state;
			wake_n_ff  <= ~resume_w;
		end
	end

	assign prdata               = prdata_ff;
	assign pready               = pready_ff;
	assign pslverr              = pslverr_ff;
	assign xcvr                 = xcvr_ff;
	assign dma_request_line_0_n = dma0_n_ff;
	assign dma_request_line_1_n = dma1_n_ff;
	assign cpu_irq_line_a_n     = irq_a_n_ff;
	assign cpu_irq_line_b_n     = irq_b_n_ff;
	assign wake_n               = wake_n_ff;

	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	pin_drive_a : assert property (
		(pte_w && !oen_w && !se0_w) |=>
		(xcvr_ff.plus_line == $past(data_w)) && (xcvr_ff.minus_line != $past(data_w)))
		else $error("pin test value drive wrong");

	pin_se0_a : assert property (
		(pte_w && !oen_w && se0_w) |=> !xcvr_ff.plus_line && !xcvr_ff.minus_line)
		else $error("pin test single-ended zero wrong");

	pin_release_a : assert property (
		(pte_w && oen_w) |=> xcvr_ff.oe_n)
		else $error("pin test release wrong");

	normal_pass_a : assert property (
		!pte_w |=> xcvr_ff == $past(nrm_xcvr))
		else $error("normal drive not passed");

	mon_zero_a : assert property (
		(!bus_power_status || !pte_w) |=> mon_ff == 8'h00)
		else $error("monitor not zero when inactive");

	mon_sleep_a : assert property (
		(mon_act && susp_w) |=>
		!mon_ff[MON_DIFF_BIT] && mon_ff[MON_DP_BIT] == $past(rx_plus_line))
		else $error("monitor asleep wrong");

	line_a_route_a : assert property (
		(|pend_a) |=> !cpu_irq_line_a_n)
		else $error("line A not asserted");

	line_b_route_a : assert property (
		!(|pend_b) |=> cpu_irq_line_b_n)
		else $error("line B asserted without flag");

	dma_route_a : assert property (
		dma_request_line_1_n == !$past(flg_ff[DAT_BANK][DAT_BI_EMPTY_BIT]))
		else $error("DMA1 not from bulk-in empty");

	wake_pulse_a : assert property (
		$fell(suspend_resume_state) |=> !wake_n ##1 wake_n)
		else $error("wake pulse wrong");

	rsv_zero_a : assert property (
		ot_ff[6:4] == 3'h0 && mon_ff[7:3] == 5'h00 && flg_ff[1][7:5] == 3'h0)
		else $error("reserved bits not zero");

	pin_enable_a : assert property (
		pte_w |=> xcvr_ff.suspend == $past(susp_w) && xcvr_ff.oe_n == $past(oen_w))
		else $error("pin test control bits not driven");

	mon_active_a : assert property (
		mon_act |=> mon_ff[MON_DM_BIT] == $past(rx_minus_line))
		else $error("monitor minus line wrong");

	mon_awake_a : assert property (
		(mon_act && !susp_w) |=>
		mon_ff[MON_DP_BIT] == $past(rx_plus_line) &&
		($past(rx_plus_line) == $past(rx_minus_line) || mon_ff[MON_DIFF_BIT] == $past(rx_plus_line)))
		else $error("monitor awake wrong");

	bus_status_a : assert property (
		$past(presetn) |->
		flg_ff[BUS_BANK][BUS_PWR_STAT_BIT] == $past(bus_power_status) &&
		flg_ff[BUS_BANK][BUS_SUSP_STAT_BIT] == $past(suspend_resume_state))
		else $error("bus status bits not mirrored");

	no_status_irq_a : assert property (
		((flg_ff[BUS_BANK] & IRQ_MASK[BUS_BANK]) == 8'h00 && flg_ff[1] == 8'h00 && flg_ff[DAT_BANK] == 8'h00)
		|=> cpu_irq_line_a_n && cpu_irq_line_b_n)
		else $error("status bits raised a request");

	ctl_flag_set_a : assert property (
		ev_ctl[4] |=> flg_ff[1][4])
		else $error("control bank flag not set");

	ctl_sel_rsv_a : assert property (
		sel_ff[1][7:5] == 3'h0)
		else $error("control select reserved bits set");

	bo_full_set_a : assert property (
		ev_dat[DAT_BO_FULL_BIT] |=> flg_ff[DAT_BANK][DAT_BO_FULL_BIT])
		else $error("bulk-out full flag not set");

	dma0_route_a : assert property (
		dma_request_line_0_n == !$past(flg_ff[DAT_BANK][DAT_BO_FULL_BIT]))
		else $error("DMA0 not from bulk-out full");

	line_a_clear_a : assert property (
		!(|pend_a) |=> cpu_irq_line_a_n)
		else $error("line A asserted without flag");

	line_b_set_a : assert property (
		(|pend_b) |=> !cpu_irq_line_b_n)
		else $error("line B not asserted");

	ctl_one_line_a : assert property (
		(|(flg_ff[1] & sel_ff[1])) |=> !cpu_irq_line_b_n)
		else $error("selected control flag missed line B");

	wake_idle_a : assert property (
		!$fell(suspend_resume_state) |=> wake_n)
		else $error("wake output without resume");

	cov_pin_test_c : cover property (pte_w && !oen_w ##1 pte_w && oen_w);
	cov_dma_c      : cover property ($fell(dma_request_line_1_n));
	cov_irq_a_c    : cover property ($fell(cpu_irq_line_a_n));
	cov_irq_b_c    : cover property ($fell(cpu_irq_line_b_n));
	cov_wake_c     : cover property ($fell(wake_n));
endmodule : ufpt_top

// ---- tb/ufpt_usb_host.sv ----
// Behavioural USB host seen through the on-chip transceiver
`timescale 1ns/1ps
module ufpt_usb_host
	import ufpt_pkg::*;
(
	input  wire ufpt_pkg::ufpt_xcvr_t xcvr,
	input  wire logic                 host_plus,
	input  wire logic                 host_minus,
	output logic                      rx_plus_line,
	output logic                      rx_minus_line,
	output logic                      rx_diff
);
	import ufpt_pkg::*;
	// Device owns the wire while its enable-low is 0, else the host drives
	assign rx_plus_line  = xcvr.oe_n ? host_plus : xcvr.plus_line;
	assign rx_minus_line = xcvr.oe_n ? host_minus : xcvr.minus_line;
	// Differential receiver follows the plus line
	assign rx_diff       = rx_plus_line;
endmodule : ufpt_usb_host

// ---- tb/tb_top.sv ----
// Self-checking bench for the pin-test and request routing block
`timescale 1ns/1ps
module tb_top;
	import ufpt_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, ev_bus;
	logic [31:0] pwdata, prdata, rs, sd;
	logic        h_p, h_m, rx_p, rx_m, rx_d, pwr, susp_st;
	logic        dma0_n, dma1_n, irq_a_n, irq_b_n, wake_n;
	logic [4:0]  ev_ctl;
	logic [5:0]  ev_dat;
	logic [32:0] me;
	logic [32:0] expq[$];
	ufpt_xcvr_t  nrm, xcvr;
	int          mismatches, checked, cyc, cnt;

	ufpt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nrm_xcvr(nrm), .xcvr(xcvr), .rx_plus_line(rx_p), .rx_minus_line(rx_m), .rx_diff(rx_d),
		.bus_power_status(pwr), .suspend_resume_state(susp_st), .ev_bus(ev_bus), .ev_ctl(ev_ctl),
		.ev_dat(ev_dat), .dma_request_line_0_n(dma0_n), .dma_request_line_1_n(dma1_n),
		.cpu_irq_line_a_n(irq_a_n), .cpu_irq_line_b_n(irq_b_n), .wake_n(wake_n));
	ufpt_usb_host i_host (.xcvr(xcvr), .host_plus(h_p), .host_minus(h_m),
		.rx_plus_line(rx_p), .rx_minus_line(rx_m), .rx_diff(rx_d));

	always #10 pclk = ~pclk;

	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : xs

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic stop_test();
		if (mismatches == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		expq.push_back(e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic pulse(input int k, input int b);
		@(posedge pclk);
		if (k == 0) ev_bus <= 8'h01 << b;
		else if (k == 1) ev_ctl <= 5'h01 << b;
		else ev_dat <= 6'h01 << b;
		@(posedge pclk);
		ev_bus <= 8'h00;
		ev_ctl <= 5'h00;
		ev_dat <= 6'h00;
	endtask : pulse

	// Takes the oldest noted answer whenever a transfer completes
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			me = expq.pop_front();
			chk("pslverr", {31'h0, me[32]}, {31'h0, pslverr});
			if (!pwrite) chk("prdata", me[31:0], prdata);
		end
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			stop_test();
		end
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, pwr, susp_st} = 5'h00;
		{paddr, pwdata, ev_bus, ev_ctl, ev_dat} = 59'h0;
		rs = 32'h0000_8f6c;
		nrm = XCVR_RST;
		{h_p, h_m} = 2'h2;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) apb(8'(4 * i), 1'b0, 32'h0, 33'h0);
		apb(8'h20, 1'b0, 32'h0, {1'b1, 32'h0});
		apb(8'h20, 1'b1, 32'hff, {1'b1, 32'h0});
		apb(OFS_IN_MON, 1'b1, 32'h07, 33'h0);
		for (int v = 0; v < 16; v++) begin
			apb(OFS_OUT_TEST, 1'b1, 32'h80 | v, 33'h0);
			repeat (2) @(posedge pclk);
			chk("suspend", {31'h0, v[3]}, {31'h0, xcvr.suspend});
			if (v[2]) chk("oe_n", 32'h1, {31'h0, xcvr.oe_n});
			else chk("lines", v[1] ? 32'h0 : {30'h0, v[0], !v[0]}, {29'h0, xcvr[2:0]});
			apb(OFS_OUT_TEST, 1'b0, 32'h0, {1'b0, 32'h80 | v});
		end
		void'(xs());
		nrm <= ufpt_xcvr_t'(rs[3:0]);
		apb(OFS_OUT_TEST, 1'b1, 32'h0f, 33'h0);
		repeat (2) @(posedge pclk);
		chk("normal drive", {28'h0, nrm}, {28'h0, xcvr});
		pwr <= 1'b1;
		for (int v = 0; v < 8; v++) begin
			h_p <= v[0];
			h_m <= v[1];
			apb(OFS_OUT_TEST, 1'b1, v[2] ? 32'h8c : 32'h84, 33'h0);
			repeat (2) @(posedge pclk);
			apb(OFS_IN_MON, 1'b0, 32'h0, {30'h0, !v[2] && v[0], v[0], v[1]});
		end
		pwr <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(OFS_IN_MON, 1'b0, 32'h0, 33'h0);
		pwr <= 1'b1;
		apb(OFS_OUT_TEST, 1'b1, 32'h04, 33'h0);
		repeat (2) @(posedge pclk);
		apb(OFS_IN_MON, 1'b0, 32'h0, 33'h0);
		pwr <= 1'b0;
		for (int k = 0; k < NUM_BANKS; k++) for (int b = 0; b < 8; b++) if (IRQ_MASK[k][b]) begin
			void'(xs());
			// Control endpoint flags 0 to 3 share one line
			sd = (k == 1 && b < 4) ? {28'h0, {4{rs[0]}}} : {31'h0, rs[0]} << b;
			apb(OFS_SEL_BUS + 8'(4 * k), 1'b1, sd, 33'h0);
			pulse(k, b);
			repeat (2) @(posedge pclk);
			chk("irq line a", {31'h0, rs[0]}, {31'h0, irq_a_n});
			chk("irq line b", {31'h0, !rs[0]}, {31'h0, irq_b_n});
			chk("dma lines", {30'h0, !(k == 2 && b == 2), !(k == 2 && b == 0)}, {30'h0, dma1_n, dma0_n});
			apb(OFS_BUS_FLG + 8'(4 * k), 1'b0, 32'h0, {25'h0, 8'h01 << b});
			apb(OFS_BUS_FLG + 8'(4 * k), 1'b1, 32'h1 << b, 33'h0);
			repeat (2) @(posedge pclk);
			chk("lines released", 32'hf, {28'h0, dma1_n, dma0_n, irq_a_n, irq_b_n});
		end
		pwr <= 1'b1;
		susp_st <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(OFS_BUS_FLG, 1'b0, 32'h0, 33'h22);
		chk("status lines", 32'h3, {30'h0, irq_a_n, irq_b_n});
		susp_st <= 1'b0;
		cnt = 0;
		repeat (6) begin
			@(posedge pclk);
			if (wake_n === 1'b0) cnt++;
		end
		chk("wake pulse", 32'h1, cnt);
		// Let the clock settle before touching the block again
		repeat (4) @(posedge pclk);
		apb(OFS_BUS_FLG, 1'b0, 32'h0, 33'h02);
		@(posedge pclk);
		stop_test();
	end
endmodule : tb_top
